// [core/ofc_params.svh]
// constants of the on-chip flash program/erase controller
// What this block does
// - erase 1 kB blocks to all ones
// - protection per 2 kB region, two blocks
// - refuse program/erase on read-only region
// - execute-only allows only instruction fetches
// - program one word, result ANDs old data
// - clocks-per-microsecond times flash signal pulses
// - invalid access sets access-violation flag
// - finished program or erase sets done flag
// - protection changes act at once, volatile
// - clear request drops that source's flag
// - per-source enable gates interrupt output
// - raw and masked status both readable
// - bad or protected erase fails, reports error
// - protection may only tighten, never loosen
// - clock setting never affects reads
`ifndef OFC_PARAMS_SVH
`define OFC_PARAMS_SVH
`define OFC_OFF_ADDR 12'h000
`define OFC_OFF_WDATA 12'h004
`define OFC_OFF_CMD 12'h008
`define OFC_OFF_CLKUS 12'h00c
`define OFC_OFF_STAT 12'h010
`define OFC_OFF_RIS 12'h014
`define OFC_OFF_IMASK 12'h018
`define OFC_OFF_MIS 12'h01c
`define OFC_OFF_ICLR 12'h020
`define OFC_OFF_PROT 12'h024
`define OFC_CMD_PROG 0
`define OFC_CMD_ERASE 1
`define OFC_INT_ACCESS 0
`define OFC_INT_DONE 1
`define OFC_STAT_BUSY 0
`define OFC_STAT_ERR 1
`define OFC_STAT_PROTERR 2
`define OFC_PROT_REGION_LSB 8
`define OFC_CLKUS_RESET 16'h007d
`define OFC_PROG_US 20
`define OFC_ERASE_US 1000
`endif

// [core/ofc_pkg.sv]
// types of the on-chip flash program/erase controller
package ofc_pkg;
   typedef enum logic [1:0] {
      PROT_RW = 2'h0,
      PROT_RO = 2'h1,
      PROT_XO = 2'h2
   } ofc_prot_t;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PROG,
      ST_ERASE
   } ofc_state_t;
endpackage : ofc_pkg

// [core/ofc_us_timer.sv]
// microsecond pulse timer for program and erase
`timescale 1ns/100ps
module ofc_us_timer #(
   parameter int US_W = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // control
   input wire logic start,
   input wire logic [15:0] clkPerUs,
   input wire logic [US_W-1:0] usCount,
   // status
   output logic running,
   output logic done
);
   logic [15:0] cyc_q;
   logic [US_W-1:0] us_q;
   logic run_q;
   logic usTick;
   logic lastUs;

   // one-cycle microsecond enable from the divider
   assign usTick = run_q && (cyc_q + 16'h0001 >= clkPerUs);
   assign lastUs = us_q + {{(US_W-1){1'b0}}, 1'b1} >= usCount;
   assign running = run_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         cyc_q <= 16'h0000;
         us_q <= '0;
         run_q <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !run_q) begin
            cyc_q <= 16'h0000;
            us_q <= '0;
            run_q <= 1'b1;
         end else if (usTick) begin
            cyc_q <= 16'h0000;
            us_q <= us_q + {{(US_W-1){1'b0}}, 1'b1};
            if (lastUs) begin
               run_q <= 1'b0;
               done <= 1'b1;
            end
         end else if (run_q) begin
            cyc_q <= cyc_q + 16'h0001;
         end
      end
   end
endmodule : ofc_us_timer

// [core/ofc_prot_table.sv]
// per-region protection levels, tighten-only
`timescale 1ns/100ps
module ofc_prot_table import ofc_pkg::*; #(
   parameter int NREG = 2,
   parameter int RW_ = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // update request
   input wire logic setReq,
   input wire logic [RW_-1:0] setRegion,
   input wire logic [1:0] setLevel,
   output logic setRefused,
   // lookups
   input wire logic [RW_-1:0] opRegion,
   output ofc_prot_t opLevel,
   input wire logic [RW_-1:0] rdRegion,
   output ofc_prot_t rdLevel,
   input wire logic [RW_-1:0] swRegion,
   output ofc_prot_t swLevel
);
   ofc_prot_t lvl_q [NREG];
   ofc_prot_t cur;
   logic validLvl;
   logic regionOk;

   assign cur = lvl_q[setRegion];
   assign validLvl = setLevel <= PROT_XO;
   assign regionOk = 32'(setRegion) < NREG;
   assign setRefused = setReq && (!validLvl || !regionOk || setLevel < cur ||
      (cur == PROT_RO && setLevel == PROT_RW));
   assign opLevel = lvl_q[opRegion];
   assign rdLevel = lvl_q[rdRegion];
   assign swLevel = lvl_q[swRegion];

   // one level per 2 kB region
   generate
      for (genvar g = 0; g < NREG; g++) begin : gReg
         always_ff @(posedge clk) begin
            if (srst) begin
               lvl_q[g] <= PROT_RW;
            end else if (setReq && !setRefused && 32'(setRegion) == g) begin
               lvl_q[g] <= ofc_prot_t'(setLevel);
            end
         end
      end
   endgenerate
endmodule : ofc_prot_table

// [core/ofc_flash_ctrl.sv]
// on-chip flash program/erase controller top
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
`include "ofc_params.svh"
module ofc_flash_ctrl import ofc_pkg::*; #(
   parameter int NBLK = 4,
   parameter int PROG_US = `OFC_PROG_US,
   parameter int ERASE_US = `OFC_ERASE_US
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // flash read port from core and debugger
   input wire logic rdReq,
   input wire logic [31:0] rdAddr,
   input wire logic rdFetch,
   output logic [31:0] rdData,
   output logic rdValid,
   output logic rdDenied,
   // status and interrupt
   output logic busy,
   output logic irq
);
   localparam int NWORD = NBLK * 256;
   localparam int NREG = (NBLK + 1) / 2;
   localparam int WA = $clog2(NWORD);
   localparam int BA = (NBLK > 1) ? $clog2(NBLK) : 1;
   localparam int RA = (NREG > 1) ? $clog2(NREG) : 1;
   localparam logic [31:0] FLASH_BYTES = 32'(NWORD * 4);

   // storage and registers
   logic [31:0] mem_q [NWORD];
   logic [31:0] addr_q;
   logic [31:0] wdata_q;
   logic [15:0] clkUs_q;
   logic [1:0] ris_q;
   logic [1:0] ris_d;
   logic [1:0] imask_q;
   logic err_q;
   logic protErr_q;
   logic [RA-1:0] protSel_q;
   ofc_state_t state_q;
   logic [31:0] opAddr_q;
   logic [31:0] opData_q;

   // apb decode
   logic apbWr;
   logic apbRd;
   logic apbAcc;
   logic mapped;
   logic [31:0] rdMux;
   assign apbAcc = psel && penable;
   assign apbWr = apbAcc && pwrite;
   assign apbRd = apbAcc && !pwrite;
   assign pready = 1'b1;
   assign mapped = paddr == `OFC_OFF_ADDR || paddr == `OFC_OFF_WDATA ||
      paddr == `OFC_OFF_CMD || paddr == `OFC_OFF_CLKUS || paddr == `OFC_OFF_STAT ||
      paddr == `OFC_OFF_RIS || paddr == `OFC_OFF_IMASK || paddr == `OFC_OFF_MIS ||
      paddr == `OFC_OFF_ICLR || paddr == `OFC_OFF_PROT;
   assign pslverr = apbAcc && !mapped;

   logic wrAddr;
   logic wrWdata;
   logic wrCmd;
   logic wrClk;
   logic wrMask;
   logic wrClr;
   logic wrProt;
   logic rdRis;
   assign wrAddr = apbWr && paddr == `OFC_OFF_ADDR;
   assign wrWdata = apbWr && paddr == `OFC_OFF_WDATA;
   assign wrCmd = apbWr && paddr == `OFC_OFF_CMD;
   assign wrClk = apbWr && paddr == `OFC_OFF_CLKUS;
   assign wrMask = apbWr && paddr == `OFC_OFF_IMASK;
   assign wrClr = apbWr && paddr == `OFC_OFF_ICLR;
   assign wrProt = apbWr && paddr == `OFC_OFF_PROT;
   assign rdRis = apbRd && paddr == `OFC_OFF_RIS;

   // command qualification
   logic cmdProg;
   logic cmdErase;
   logic idle;
   logic inRange;
   logic aligned;
   logic [RA-1:0] cmdRegion;
   ofc_prot_t cmdLevel;
   logic cmdProtected;
   logic cmdBad;
   logic cmdStart;
   assign idle = state_q == ST_IDLE;
   assign cmdProg = wrCmd && pwdata[`OFC_CMD_PROG] && !pwdata[`OFC_CMD_ERASE];
   assign cmdErase = wrCmd && pwdata[`OFC_CMD_ERASE] && !pwdata[`OFC_CMD_PROG];
   assign inRange = addr_q < FLASH_BYTES;
   assign aligned = addr_q[1:0] == 2'h0;
   assign cmdRegion = RA'(addr_q >> 11);
   assign cmdProtected = cmdLevel != PROT_RW;
   // invalid block or protected block fails
   assign cmdBad = (cmdProg || cmdErase) &&
      (!idle || !inRange || cmdProtected || (cmdProg && !aligned));
   assign cmdStart = (cmdProg || cmdErase) && !cmdBad;

   // read port checks
   logic [RA-1:0] rdRegion;
   ofc_prot_t rdLevel;
   logic rdInRange;
   logic rdBlocked;
   assign rdRegion = RA'(rdAddr >> 11);
   assign rdInRange = rdAddr < FLASH_BYTES;
   // data reads of execute-only are blocked
   assign rdBlocked = !rdInRange || (rdLevel == PROT_XO && !rdFetch);

   // protection table
   logic protRefused;
   ofc_prot_t swLevel;
   ofc_prot_table #(
      .NREG(NREG),
      .RW_(RA)
   ) uProt (
      .clk(clk),
      .srst(srst),
      .setReq(wrProt),
      .setRegion(RA'(pwdata[`OFC_PROT_REGION_LSB +: 8])),
      .setLevel(pwdata[1:0]),
      .setRefused(protRefused),
      .opRegion(cmdRegion),
      .opLevel(cmdLevel),
      .rdRegion(rdRegion),
      .rdLevel(rdLevel),
      .swRegion(protSel_q),
      .swLevel(swLevel)
   );

   // operation timer
   logic tmrDone;
   logic [19:0] usCount;
   assign usCount = (state_q == ST_ERASE) ? 20'(ERASE_US) : 20'(PROG_US);
   ofc_us_timer #(
      .US_W(20)
   ) uTmr (
      .clk(clk),
      .srst(srst),
      .start(cmdStart),
      .clkPerUs(clkUs_q),
      .usCount(usCount),
      .running(),
      .done(tmrDone)
   );

   // sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (cmdStart) begin
                  state_q <= cmdErase ? ST_ERASE : ST_PROG;
               end
            end
            ST_PROG, ST_ERASE: begin
               if (tmrDone) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         opAddr_q <= 32'h0;
         opData_q <= 32'h0;
      end else if (cmdStart) begin
         opAddr_q <= addr_q;
         opData_q <= wdata_q;
      end
   end

   assign busy = !idle;

   // flash array writes at end of pulse
   logic progEnd;
   logic eraseEnd;
   logic [WA-1:0] opWord;
   logic [BA-1:0] opBlk;
   assign progEnd = state_q == ST_PROG && tmrDone;
   assign eraseEnd = state_q == ST_ERASE && tmrDone;
   assign opWord = WA'(opAddr_q >> 2);
   assign opBlk = BA'(opAddr_q >> 10);
   generate
      for (genvar w = 0; w < NWORD; w++) begin : gWord
         always_ff @(posedge clk) begin
            // whole 1 kB block to all ones
            if (eraseEnd && 32'(opBlk) == w / 256) begin
               mem_q[w] <= 32'hffffffff;
            end else if (progEnd && 32'(opWord) == w) begin
               mem_q[w] <= mem_q[w] & opData_q;
            end
         end
      end
   endgenerate

   // read port, independent of the timing setting
   logic [WA-1:0] rdWord;
   assign rdWord = WA'(rdAddr >> 2);
   // reads never use the clock setting
   always_ff @(posedge clk) begin
      if (srst) begin
         rdData <= 32'h0;
         rdValid <= 1'b0;
         rdDenied <= 1'b0;
      end else begin
         rdValid <= rdReq && !rdBlocked;
         rdDenied <= rdReq && rdBlocked;
         rdData <= (rdReq && !rdBlocked) ? mem_q[rdWord] : 32'h0;
      end
   end

   // software registers
   always_ff @(posedge clk) begin
      if (srst) begin
         addr_q <= 32'h0;
         wdata_q <= 32'hffffffff;
         clkUs_q <= `OFC_CLKUS_RESET;
         imask_q <= 2'h0;
         protSel_q <= '0;
      end else begin
         if (wrAddr) begin
            addr_q <= pwdata;
         end
         if (wrWdata) begin
            wdata_q <= pwdata;
         end
         if (wrClk && idle) begin
            clkUs_q <= (pwdata[15:0] == 16'h0) ? 16'h0001 : pwdata[15:0];
         end
         if (wrMask) begin
            imask_q <= pwdata[1:0];
         end
         if (wrProt) begin
            protSel_q <= RA'(pwdata[`OFC_PROT_REGION_LSB +: 8]);
         end
      end
   end

   // command error cleared by next good command, protection error by next accepted protection write
   always_ff @(posedge clk) begin
      if (srst) begin
         err_q <= 1'b0;
         protErr_q <= 1'b0;
      end else begin
         if (cmdBad) begin
            err_q <= 1'b1;
         end else if (cmdStart) begin
            err_q <= 1'b0;
         end
         if (wrProt) begin
            protErr_q <= protRefused;
         end
      end
   end

   // interrupt status, set wins over clear
   logic [1:0] evt;
   logic [1:0] clrMask;
   // refused operation or read raises violation
   assign evt[`OFC_INT_ACCESS] = cmdBad || (rdReq && rdBlocked) || (wrProt && protRefused);
   // done on program or erase finish
   assign evt[`OFC_INT_DONE] = progEnd || eraseEnd;
   assign clrMask = (wrClr ? pwdata[1:0] : 2'h0) | (rdRis ? 2'h3 : 2'h0);
   assign ris_d = (ris_q & ~clrMask) | evt;
   always_ff @(posedge clk) begin
      if (srst) begin
         ris_q <= 2'h0;
      end else begin
         ris_q <= ris_d;
      end
   end

   assign irq = |(ris_q & imask_q);

   // read mux
   logic [31:0] statWord;
   assign statWord = {29'h0, protErr_q, err_q, busy};
   always_comb begin
      rdMux = 32'h0;
      unique case (paddr)
         `OFC_OFF_ADDR: rdMux = addr_q;
         `OFC_OFF_WDATA: rdMux = wdata_q;
         `OFC_OFF_CLKUS: rdMux = {16'h0, clkUs_q};
         `OFC_OFF_STAT: rdMux = statWord;
         `OFC_OFF_RIS: rdMux = {30'h0, ris_q};
         `OFC_OFF_IMASK: rdMux = {30'h0, imask_q};
         `OFC_OFF_MIS: rdMux = {30'h0, ris_q & imask_q};
         `OFC_OFF_PROT: rdMux = {30'h0, swLevel};
         default: rdMux = 32'h0;
      endcase
   end
   assign prdata = apbRd ? rdMux : 32'h0;
endmodule : ofc_flash_ctrl

// [bench/ofc_flash_ctrl_asserts.sv]
// port assertions of the flash program/erase controller
`timescale 1ns/100ps
module ofc_flash_ctrl_asserts #(
   parameter int NBLK = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // read port and status
   input wire logic rdReq,
   input wire logic [31:0] rdAddr,
   input wire logic rdFetch,
   input wire logic [31:0] rdData,
   input wire logic rdValid,
   input wire logic rdDenied,
   input wire logic busy,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   a_rd_answer: assert property (rdReq |=> rdValid != rdDenied)
      else $error("read request not answered exactly once");
   a_rd_quiet: assert property (!rdReq |=> !rdValid && !rdDenied)
      else $error("read answer without request");
   a_fetch_allowed: assert property (rdReq && rdFetch && rdAddr < NBLK * 1024 |=> rdValid)
      else $error("instruction fetch refused");
   a_denied_zero: assert property (rdDenied |-> rdData == 32'h0)
      else $error("denied read leaks data");
   a_zero_wait: assert property (psel |-> pready)
      else $error("apb wait state seen");
   a_unmapped_err: assert property (psel && penable && paddr > 12'h024 |-> pslverr)
      else $error("unmapped access not flagged");
   a_prdata_idle: assert property (!(psel && penable) |-> prdata == 32'h0)
      else $error("read data outside access phase");
   a_busy_cause: assert property ($rose(busy) |-> $past(psel && penable && pwrite
      && paddr == 12'h008))
      else $error("busy without command write");
   a_busy_bound: assert property ($rose(busy) |-> busy [*2] ##[1:1000] !busy)
      else $error("operation length out of bounds");
   a_irq_fall: assert property ($fell(irq) |-> $past(psel && penable))
      else $error("interrupt dropped without access");
endmodule : ofc_flash_ctrl_asserts

bind ofc_flash_ctrl ofc_flash_ctrl_asserts #(.NBLK(NBLK)) u_ofc_flash_ctrl_asserts (
   .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rdReq(rdReq), .rdAddr(rdAddr), .rdFetch(rdFetch), .rdData(rdData),
   .rdValid(rdValid), .rdDenied(rdDenied), .busy(busy), .irq(irq));

// [bench/ofc_core_model.sv]
// core and debugger side of the flash read port
`timescale 1ns/100ps
module ofc_core_model (
   // clock
   input wire logic clk,
   // request
   output logic rdReq,
   output logic [31:0] rdAddr,
   output logic rdFetch,
   // answer
   input wire logic [31:0] rdData,
   input wire logic rdValid,
   input wire logic rdDenied
);
   initial begin
      rdReq = 1'b0;
      rdAddr = 32'h0;
      rdFetch = 1'b0;
   end
   task automatic rd(input logic [31:0] a, input logic f, output logic [33:0] r);
      @(posedge clk);
      rdReq <= 1'b1;
      rdAddr <= {a[31:2], 2'b00};
      rdFetch <= f;
      @(posedge clk);
      rdReq <= 1'b0;
      rdAddr <= ~{a[31:2], 2'b00};
      rdFetch <= ~f;
      @(posedge clk);
      r = {rdValid, rdDenied, rdData};
   endtask : rd
endmodule : ofc_core_model

// [bench/testbench.sv]
// self-checking testbench of the flash controller
`timescale 1ns/100ps
module testbench;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdAddr, rdData;
   logic pready, pslverr, rdReq, rdFetch, rdValid, rdDenied, busy, irq;
   logic [33:0] r;
   int err_total = 0;
   int n_checks = 0;

   always #4 clk = ~clk;

   ofc_flash_ctrl #(.NBLK(4), .PROG_US(2), .ERASE_US(5)) u_ofc_flash_ctrl (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rdReq(rdReq), .rdAddr(rdAddr), .rdFetch(rdFetch),
      .rdData(rdData), .rdValid(rdValid), .rdDenied(rdDenied), .busy(busy), .irq(irq));
   ofc_core_model u_ofc_core_model (
      .clk(clk), .rdReq(rdReq), .rdAddr(rdAddr), .rdFetch(rdFetch),
      .rdData(rdData), .rdValid(rdValid), .rdDenied(rdDenied));

   task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [32:0] q);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [32:0] q;
      apb(1'b1, a, d, q);
   endtask : wr

   task automatic rr(input string n, input logic [11:0] a, input logic [32:0] e);
      logic [32:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(n, e, q);
   endtask : rr

   task automatic fr(input string n, input logic [31:0] a, input logic f,
         input logic [33:0] e);
      u_ofc_core_model.rd(a, f, r);
      chk(n, e, r);
   endtask : fr

   task automatic op(input logic [31:0] a, input logic [31:0] c, input logic b);
      int k;
      wr(12'h000, a);
      wr(12'h008, c);
      repeat (2) @(posedge clk);
      chk("busy", b, busy);
      k = 0;
      while (busy !== 1'b0 && k < 100) begin
         @(posedge clk);
         k++;
      end
      chk("busy end", 0, busy);
   endtask : op

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      #100000;
      err_total++;
      end_sim;
   end

   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      rr("clkus", 12'h00c, 32'h7d);
      rr("mask", 12'h018, 32'h0);
      rr("raw", 12'h014, 32'h0);
      rr("unmapped", 12'h040, 33'h100000000);
      $display("test reset done");
      wr(12'h00c, 32'h1);
      op(32'h0, 32'h2, 1'b1);
      fr("erase lo", 32'h0, 1'b0, {2'b10, 32'hffffffff});
      fr("erase hi", 32'h3fc, 1'b0, {2'b10, 32'hffffffff});
      chk("irq masked", 0, irq);
      wr(12'h018, 32'h2);
      rr("masked", 12'h01c, 32'h2);
      chk("irq on", 1, irq);
      wr(12'h020, 32'h2);
      rr("raw clr", 12'h014, 32'h0);
      chk("irq off", 0, irq);
      $display("test erase done");
      wr(12'h004, 32'hf0f0ffff);
      op(32'h4, 32'h1, 1'b1);
      wr(12'h004, 32'h0ff0ff00);
      op(32'h4, 32'h1, 1'b1);
      fr("and", 32'h4, 1'b0, {2'b10, 32'h00f0ff00});
      $display("test program done");
      wr(12'h024, 32'h1);
      fr("ro read", 32'h4, 1'b0, {2'b10, 32'h00f0ff00});
      op(32'h0, 32'h2, 1'b0);
      rr("status", 12'h010, 32'h2);
      wr(12'h004, 32'h0);
      op(32'h4, 32'h1, 1'b0);
      fr("ro kept", 32'h4, 1'b0, {2'b10, 32'h00f0ff00});
      rr("raw acc", 12'h014, 32'h3);
      rr("raw rdclr", 12'h014, 32'h0);
      wr(12'h024, 32'h0);
      rr("prot err", 12'h010, 32'h6);
      rr("prot", 12'h024, 32'h1);
      op(32'h800, 32'h2, 1'b1);
      fr("rgn1", 32'h800, 1'b0, {2'b10, 32'hffffffff});
      wr(12'h024, 32'h2);
      rr("prot xo", 12'h024, 32'h2);
      fr("xo data", 32'h4, 1'b0, {2'b01, 32'h0});
      fr("xo fetch", 32'h4, 1'b1, {2'b10, 32'h00f0ff00});
      rr("raw xo", 12'h014, 32'h3);
      op(32'h1000, 32'h2, 1'b0);
      rr("raw bad", 12'h014, 32'h1);
      op(32'h800, 32'h3, 1'b0);
      rr("raw noop", 12'h014, 32'h0);
      $display("test protection done");
      wr(12'h00c, 32'h3);
      rr("clkus", 12'h00c, 32'h3);
      fr("rd clk", 32'h800, 1'b0, {2'b10, 32'hffffffff});
      $display("test clock done");
      end_sim;
   end
endmodule : testbench
